/* File: core/rsc_pkg.sv */
// constants and carrier types of the radio status and threshold registers
package rsc_pkg;
	// ======================================================
	// register map
	localparam logic [5:0] ADDR_TX_AMP   = 6'h30;
	localparam logic [5:0] ADDR_STATE    = 6'h32;
	localparam logic [5:0] ADDR_FLAGS    = 6'h33;
	localparam logic [5:0] ADDR_RX_THR   = 6'h34;
	localparam logic [5:0] ADDR_TIMING   = 6'h35;
	localparam logic [5:0] ADDR_CLR_THR  = 6'h36;
	localparam logic [7:0] RST_TX_AMP    = 8'h06;
	localparam logic [6:0] RST_RX_THR    = 7'h40;
	localparam logic [1:0] RST_TIMING    = 2'h1;
	localparam logic [7:0] RST_CLR_THR   = 8'he0;
	localparam int         TIM_SLOT_BIT  = 1;
	localparam int         TIM_HOLD_BIT  = 0;
	// ======================================================
	// serial command byte: top two bits select the access
	localparam logic [1:0] CMD_READ      = 2'h2;
	localparam logic [1:0] CMD_WRITE     = 2'h3;
	localparam logic [3:0] BIT_CMD_LAST  = 4'h7;
	localparam logic [3:0] BIT_DATA_LAST = 4'hf;
	// ======================================================
	// channel-clear modes
	localparam logic [1:0] CCA_ALWAYS    = 2'h0;
	localparam logic [1:0] CCA_LEVEL     = 2'h1;
	localparam logic [1:0] CCA_IDLE      = 2'h2;
	// ======================================================
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SYMBOL_NS     = 16000;
	localparam int SYM_CYC       = SYMBOL_NS / CLK_PERIOD_NS;
	localparam int ACK_SYMS      = 12;
	localparam int HOLDOFF_SYMS  = 12;
	localparam int WAIT_CYC_DEF  = ACK_SYMS * SYM_CYC;
	localparam int HOLD_CYC_DEF  = HOLDOFF_SYMS * SYM_CYC;
	// ======================================================
	// radio core inputs, all on clk_sys
	typedef struct packed {
		logic [5:0] ffState;
		logic       ffTxState;
		logic       ffRxState;
		logic       calActive;
		logic       calFinish;
		logic       synthLock;
		logic       rxOverflow;
		logic       rxFrameAvail;
		logic [7:0] rxCount;
		logic [7:0] rxFilteredCount;
		logic       rxPop;
		logic       txSfdSent;
		logic       txFrameDone;
		logic       rxSfdSeen;
		logic       rxFrameDone;
		logic       ackRequested;
		logic       slotBoundary;
		logic       rxReceiving;
		logic [7:0] rssi;
		logic [1:0] clrMode;
		logic [2:0] clrHyst;
	} rsc_core_s;
endpackage : rsc_pkg

/* File: core/rsc_regs.sv */
// radio status, receive threshold, frame timing and channel-clear registers
`timescale 1ns/1ps
module rsc_regs
	import rsc_pkg::*;
#(
	parameter int ACK_WAIT_CYC = WAIT_CYC_DEF,
	parameter int HOLDOFF_CYC  = HOLD_CYC_DEF
) (
	input  wire logic      clk_sys,
	input  wire logic      rst,
	input  wire logic      spiCs_n,
	input  wire logic      spiSclk,
	input  wire logic      spiMosi,
	output logic           spiMiso,
	output logic           spiMisoOe_n,
	input  wire rsc_core_s core,
	input  wire logic      sampleClearStrobe,
	input  wire logic      txIfClearStrobe,
	output logic [7:0]     txAmpLevel,
	output logic           rxBufferThresholdFlag,
	output logic           channelClear,
	output logic           ackTxStart,
	output logic           rxHoldoff
);
	// ======================================================
	// pin synchronisers
	logic [1:0] csSync_q, sclkSync_q, mosiSync_q;
	logic       sclkPrev_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			csSync_q   <= 2'h3;
			sclkSync_q <= 2'h0;
			mosiSync_q <= 2'h0;
			sclkPrev_q <= 1'b0;
		end else begin
			csSync_q   <= {csSync_q[0], spiCs_n};
			sclkSync_q <= {sclkSync_q[0], spiSclk};
			mosiSync_q <= {mosiSync_q[0], spiMosi};
			sclkPrev_q <= sclkSync_q[1];
		end
	end
	logic selected, sclkRise, sclkFall;
	assign selected = !csSync_q[1];
	assign sclkRise = selected && sclkSync_q[1] && !sclkPrev_q;
	assign sclkFall = selected && !sclkSync_q[1] && sclkPrev_q;

	// ======================================================
	// writable registers
	logic [7:0] txAmp_q, clrThr_q;
	logic [6:0] rxThr_q;
	logic [1:0] timing_q;
	logic       wrEn;
	logic [5:0] wrAddr;
	logic [7:0] wrData;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			txAmp_q  <= RST_TX_AMP;
			rxThr_q  <= RST_RX_THR;
			timing_q <= RST_TIMING;
			clrThr_q <= RST_CLR_THR;
		end else if (wrEn) begin
			case (wrAddr)
				ADDR_TX_AMP:  txAmp_q  <= wrData;
				ADDR_RX_THR:  rxThr_q  <= wrData[6:0];
				ADDR_TIMING:  timing_q <= wrData[1:0];
				ADDR_CLR_THR: clrThr_q <= wrData;
				default: ;
			endcase
		end
	end

	// ======================================================
	// status flags
	logic sfdFlag_q, ccaLive_q, ccaSampled_q, ccaLevel_q, thrFlag_q;
	logic calFinish_q, nonEmpty_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sfdFlag_q <= 1'b0;
		end else if (core.txSfdSent || core.rxSfdSeen) begin
			sfdFlag_q <= 1'b1;
		end else if (core.txFrameDone || core.rxFrameDone) begin
			sfdFlag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			calFinish_q <= 1'b0;
			nonEmpty_q  <= 1'b0;
		end else begin
			calFinish_q <= core.calFinish;
			nonEmpty_q  <= (core.rxCount != 8'h00)
				&& !core.rxOverflow;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			thrFlag_q <= 1'b0;
		end else if (core.rxOverflow || core.rxFrameAvail
			|| (core.rxFilteredCount > {1'b0, rxThr_q})) begin
			thrFlag_q <= 1'b1;
		end else if (core.rxPop && core.rxCount < {1'b0, rxThr_q}) begin
			thrFlag_q <= 1'b0;
		end
	end

	// signal level with hysteresis; sign-extended to avoid wrap
	logic signed [8:0] rssiExt, thrExt, thrLow;
	assign rssiExt = {core.rssi[7], core.rssi};
	assign thrExt  = {clrThr_q[7], clrThr_q};
	assign thrLow  = thrExt - $signed({6'h00, core.clrHyst});
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ccaLevel_q <= 1'b0;
		end else if (rssiExt >= thrExt) begin
			ccaLevel_q <= 1'b0;
		end else if (rssiExt < thrLow) begin
			ccaLevel_q <= 1'b1;
		end
	end

	logic ccaNext;
	always_comb begin
		case (core.clrMode)
			CCA_ALWAYS: ccaNext = 1'b1;
			CCA_LEVEL:  ccaNext = ccaLevel_q;
			CCA_IDLE:   ccaNext = !core.rxReceiving;
			default:    ccaNext = ccaLevel_q && !core.rxReceiving;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ccaLive_q <= 1'b0;
		end else begin
			ccaLive_q <= ccaNext;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ccaSampled_q <= 1'b0;
		end else if (sampleClearStrobe || txIfClearStrobe) begin
			ccaSampled_q <= ccaLive_q;
		end
	end

	// ======================================================
	// acknowledge timing and receive holdoff
	typedef enum logic [1:0] {
		ACK_IDLE = 2'b00,
		ACK_WAIT = 2'b01,
		ACK_SLOT = 2'b10
	} rsc_ack_e;
	rsc_ack_e  ackSt_q;
	logic [31:0] ackCnt_q, holdCnt_q;
	logic      ackStart_q, hold_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ackSt_q    <= ACK_IDLE;
			ackCnt_q   <= 32'h0;
			ackStart_q <= 1'b0;
		end else begin
			ackStart_q <= 1'b0;
			case (ackSt_q)
				ACK_IDLE: begin
					if (core.rxFrameDone && core.ackRequested) begin
						ackSt_q  <= ACK_WAIT;
						ackCnt_q <= 32'h1;
					end
				end
				ACK_WAIT: begin
					if (ackCnt_q < ACK_WAIT_CYC) begin
						ackCnt_q <= ackCnt_q + 32'h1;
					end else if (timing_q[TIM_SLOT_BIT]) begin
						ackSt_q <= ACK_SLOT;
					end else begin
						ackStart_q <= 1'b1;
						ackSt_q    <= ACK_IDLE;
					end
				end
				ACK_SLOT: begin
					if (core.slotBoundary) begin
						ackStart_q <= 1'b1;
						ackSt_q    <= ACK_IDLE;
					end
				end
				default: ackSt_q <= ACK_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			holdCnt_q <= 32'h0;
			hold_q    <= 1'b0;
		end else if (core.rxFrameDone && timing_q[TIM_HOLD_BIT]) begin
			holdCnt_q <= 32'h1;
			hold_q    <= 1'b1;
		end else if (hold_q && holdCnt_q >= HOLDOFF_CYC) begin
			hold_q <= 1'b0;
		end else if (hold_q) begin
			holdCnt_q <= holdCnt_q + 32'h1;
		end
	end

	// ======================================================
	// read mux and serial shifter
	function automatic logic [7:0] regRead(input logic [5:0] a);
		case (a)
			ADDR_TX_AMP:  regRead = txAmp_q;
			ADDR_STATE:   regRead = {calFinish_q, core.calActive,
				core.ffState};
			ADDR_FLAGS:   regRead = {nonEmpty_q, thrFlag_q, sfdFlag_q,
				ccaLive_q, ccaSampled_q, core.synthLock, core.ffTxState,
				core.ffRxState};
			ADDR_RX_THR:  regRead = {1'b0, rxThr_q};
			ADDR_TIMING:  regRead = {6'h00, timing_q};
			ADDR_CLR_THR: regRead = clrThr_q;
			default:      regRead = 8'h00;
		endcase
	endfunction : regRead

	logic [3:0] bitCnt_q;
	logic [7:0] rxSh_q, txSh_q, cmd_q;
	logic       miso_q, misoOe_q;
	assign wrEn   = sclkRise && bitCnt_q == BIT_DATA_LAST
		&& cmd_q[7:6] == CMD_WRITE;
	assign wrAddr = cmd_q[5:0];
	assign wrData = {rxSh_q[6:0], mosiSync_q[1]};
	always_ff @(posedge clk_sys) begin
		if (rst || !selected) begin
			bitCnt_q <= 4'h0;
			rxSh_q   <= 8'h00;
			cmd_q    <= 8'h00;
		end else if (sclkRise) begin
			bitCnt_q <= bitCnt_q + 4'h1;
			rxSh_q   <= wrData;
			if (bitCnt_q == BIT_CMD_LAST) begin
				cmd_q <= wrData;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst || !selected) begin
			txSh_q   <= 8'h00;
			miso_q   <= 1'b0;
			misoOe_q <= 1'b1;
		end else begin
			misoOe_q <= 1'b0;
			if (sclkRise && bitCnt_q == BIT_CMD_LAST) begin
				txSh_q <= (wrData[7:6] == CMD_READ)
					? regRead(wrData[5:0]) : 8'h00;
			end else if (sclkFall && bitCnt_q > BIT_CMD_LAST) begin
				miso_q <= txSh_q[7];
				txSh_q <= {txSh_q[6:0], 1'b0};
			end
		end
	end

	// ======================================================
	// outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			txAmpLevel            <= RST_TX_AMP;
			rxBufferThresholdFlag <= 1'b0;
			channelClear          <= 1'b0;
			ackTxStart            <= 1'b0;
			rxHoldoff             <= 1'b0;
			spiMiso               <= 1'b0;
			spiMisoOe_n           <= 1'b1;
		end else begin
			txAmpLevel            <= txAmp_q;
			rxBufferThresholdFlag <= thrFlag_q;
			channelClear          <= ccaLive_q;
			ackTxStart            <= ackStart_q;
			rxHoldoff             <= hold_q;
			spiMiso               <= miso_q;
			spiMisoOe_n           <= misoOe_q;
		end
	end

	// ======================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence frameEndAck;
		core.rxFrameDone && core.ackRequested && ackSt_q == ACK_IDLE
			&& !timing_q[TIM_SLOT_BIT];
	endsequence
	cal_pulse_a: assert property (core.calFinish |=> calFinish_q
		##1 (calFinish_q == $past(core.calFinish)))
		else $error("calibration finish not a one-cycle copy");
	nonempty_ovf_a: assert property (core.rxOverflow |=> !nonEmpty_q)
		else $error("nonempty flag high during overflow");
	thr_ovf_a: assert property (core.rxOverflow |=> ##1
		rxBufferThresholdFlag)
		else $error("threshold flag low during overflow");
	thr_frame_a: assert property (core.rxFrameAvail |=> thrFlag_q)
		else $error("threshold flag low with complete frame");
	latched_channel_clear_a: assert property (
		(sampleClearStrobe || txIfClearStrobe)
		|=> ccaSampled_q == $past(ccaLive_q))
		else $error("sampled clear value not latched");
	mode_always_a: assert property (
		core.clrMode == CCA_ALWAYS |=> ccaLive_q)
		else $error("clear result low in always mode");
	busy_level_a: assert property (rssiExt >= thrExt |=> !ccaLevel_q)
		else $error("level clear while at or above threshold");
	sfd_set_a: assert property (
		(core.txSfdSent || core.rxSfdSeen) |=> sfdFlag_q)
		else $error("delimiter flag not set");
	ack_unslotted_a: assert property (
		frameEndAck |=> !ackStart_q [*2])
		else $error("acknowledge started too early");
	hold_off_a: assert property (
		core.rxFrameDone && !timing_q[TIM_HOLD_BIT] && !hold_q |=> !hold_q)
		else $error("holdoff applied while disabled");
endmodule : rsc_regs

/* File: sim/rsc_host_model.sv */
// host side model: serial master for register access
`timescale 1ns/1ps
module rsc_host_model
	import rsc_pkg::*;
#(
	parameter int HALF_CYC = 6
) (
	input  wire logic clk_sys,
	output logic      spiCs_n,
	output logic      spiSclk,
	output logic      spiMosi,
	input  wire logic spiMiso,
	input  wire logic spiMisoOe_n
);
	logic misoLast;
	logic misoWire;

	// a released data line shows the inverse of its last driven level
	always_ff @(posedge clk_sys) begin
		if (!spiMisoOe_n) begin
			misoLast <= spiMiso;
		end
	end
	assign misoWire = spiMisoOe_n ? ~misoLast : spiMiso;

	initial begin
		spiCs_n = 1'b1;
		spiSclk = 1'b0;
		spiMosi = 1'b0;
	end

	// ====================================================
	// one command byte and one data byte, msb first, mode 0
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
		output logic [7:0] rdat);
		logic [15:0] frame;
		frame = {cmd, dat};
		rdat = 8'h00;
		@(posedge clk_sys);
		spiCs_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spiMosi <= frame[i];
			repeat (HALF_CYC) @(posedge clk_sys);
			spiSclk <= 1'b1;
			if (i < 8) begin
				rdat[i] = misoWire;
			end
			repeat (HALF_CYC) @(posedge clk_sys);
			spiSclk <= 1'b0;
		end
		repeat (HALF_CYC) @(posedge clk_sys);
		spiCs_n <= 1'b1;
		repeat (HALF_CYC) @(posedge clk_sys);
	endtask : xfer
endmodule : rsc_host_model

/* File: sim/radio_status_fifo_cca_regs_bench.sv */
// self-checking bench for the radio status and threshold registers
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	#1; \
	total_checks++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("mismatch at %0t: got %h want %h", $time, got, exp); \
	end \
	@(posedge clk_sys); \
end
module radio_status_fifo_cca_regs_bench
	import rsc_pkg::*;
;
	localparam int ACK_CYC  = 20;
	localparam int HOLD_CYC = 20;
	logic        clk_sys;
	logic        rst;
	logic        spiCs_n;
	logic        spiSclk;
	logic        spiMosi;
	logic        spiMiso;
	logic        spiMisoOe_n;
	logic        sampleClearStrobe;
	logic        txIfClearStrobe;
	logic        rxBufferThresholdFlag;
	logic        channelClear;
	logic        ackTxStart;
	logic        rxHoldoff;
	logic [7:0]  txAmpLevel;
	logic [7:0]  rdat;
	rsc_core_s   core;
	int          errors;
	int          total_checks;
	int          cycles;
	int          ackAt;
	int          holdCnt;
	logic [5:0]  regAddr [7] = '{6'h30, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36,
		6'h31};
	logic [7:0]  rstVal [7] = '{8'h06, 8'h00, 8'h00, 8'h40, 8'h01, 8'he0,
		8'h00};
	// mode, receiving, expected clear, signal level
	logic [11:0] ccaTab [11] = '{12'h5ec, 12'h4f8, 12'h4f7, 12'h5f5, 12'h5f7,
		12'h1f8, 12'haf8, 12'h9f8, 12'heec, 12'hdec, 12'hcf8};

	rsc_regs #(
		.ACK_WAIT_CYC (ACK_CYC),
		.HOLDOFF_CYC  (HOLD_CYC)
	) u_rsc_regs (
		.clk_sys               (clk_sys),
		.rst                   (rst),
		.spiCs_n               (spiCs_n),
		.spiSclk               (spiSclk),
		.spiMosi               (spiMosi),
		.spiMiso               (spiMiso),
		.spiMisoOe_n           (spiMisoOe_n),
		.core                  (core),
		.sampleClearStrobe     (sampleClearStrobe),
		.txIfClearStrobe       (txIfClearStrobe),
		.txAmpLevel            (txAmpLevel),
		.rxBufferThresholdFlag (rxBufferThresholdFlag),
		.channelClear          (channelClear),
		.ackTxStart            (ackTxStart),
		.rxHoldoff             (rxHoldoff)
	);
	rsc_host_model u_rsc_host_model (
		.clk_sys     (clk_sys),
		.spiCs_n     (spiCs_n),
		.spiSclk     (spiSclk),
		.spiMosi     (spiMosi),
		.spiMiso     (spiMiso),
		.spiMisoOe_n (spiMisoOe_n)
	);

	initial clk_sys = 1'b0;
	always #10 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	// ====================================================
	// tasks
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
	endtask : tick
	task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
		u_rsc_host_model.xfer({CMD_READ, a}, 8'h00, rdat);
		`CHK(rdat, e)
	endtask : chk_rd
	task automatic chk_wr(input logic [5:0] a, input logic [7:0] d,
		input logic [7:0] e);
		u_rsc_host_model.xfer({CMD_WRITE, a}, d, rdat);
		chk_rd(a, e);
	endtask : chk_wr
	task automatic pulse(input int which);
		@(posedge clk_sys);
		case (which)
			0: core.txSfdSent <= 1'b1;
			1: core.txFrameDone <= 1'b1;
			2: core.rxSfdSeen <= 1'b1;
			3: core.rxFrameDone <= 1'b1;
			4: core.rxPop <= 1'b1;
			5: sampleClearStrobe <= 1'b1;
			6: txIfClearStrobe <= 1'b1;
			default: core.calFinish <= 1'b1;
		endcase
		@(posedge clk_sys);
		core.txSfdSent <= 1'b0;
		core.txFrameDone <= 1'b0;
		core.rxSfdSeen <= 1'b0;
		core.rxFrameDone <= 1'b0;
		core.rxPop <= 1'b0;
		sampleClearStrobe <= 1'b0;
		txIfClearStrobe <= 1'b0;
		core.calFinish <= 1'b0;
	endtask : pulse
	task automatic set_cca(input logic [11:0] e);
		@(posedge clk_sys);
		core.clrMode <= e[11:10];
		core.rxReceiving <= e[9];
		core.rssi <= e[7:0];
		tick(5);
	endtask : set_cca
	// slot boundaries fall early in the wait and well after it
	task automatic frame_end();
		ackAt = -1;
		holdCnt = 0;
		pulse(3);
		for (int k = 1; k <= 60; k++) begin
			@(posedge clk_sys);
			core.slotBoundary <= (k == 4 || k == 30);
			#1;
			if (ackTxStart === 1'b1 && ackAt < 0) begin
				ackAt = k;
			end
			if (rxHoldoff === 1'b1) begin
				holdCnt++;
			end
		end
	endtask : frame_end

	// ====================================================
	// sequence
	initial begin
		rst = 1'b1;
		core = '0;
		core.clrMode = CCA_LEVEL;
		sampleClearStrobe = 1'b0;
		txIfClearStrobe = 1'b0;
		tick(5);
		rst <= 1'b0;
		tick(3);
		`CHK(txAmpLevel, 8'h06)
		`CHK(channelClear, 1'b0)
		for (int i = 0; i < 7; i++) begin
			chk_rd(regAddr[i], rstVal[i]);
		end
		chk_wr(ADDR_TX_AMP, 8'h5a, 8'h5a);
		`CHK(txAmpLevel, 8'h5a)
		chk_wr(ADDR_RX_THR, 8'hff, 8'h7f);
		chk_wr(ADDR_TIMING, 8'hff, 8'h03);
		chk_wr(ADDR_STATE, 8'hff, 8'h00);
		chk_wr(6'h31, 8'hff, 8'h00);
		chk_wr(ADDR_RX_THR, 8'h05, 8'h05);
		core.rxCount <= 8'h06;
		core.rxFilteredCount <= 8'h06;
		tick(3);
		`CHK(rxBufferThresholdFlag, 1'b1)
		chk_rd(ADDR_FLAGS, 8'hc0);
		core.rxCount <= 8'h04;
		core.rxFilteredCount <= 8'h04;
		pulse(4);
		tick(3);
		`CHK(rxBufferThresholdFlag, 1'b0)
		core.rxFrameAvail <= 1'b1;
		tick(3);
		`CHK(rxBufferThresholdFlag, 1'b1)
		core.rxFrameAvail <= 1'b0;
		core.rxOverflow <= 1'b1;
		pulse(4);
		tick(3);
		`CHK(rxBufferThresholdFlag, 1'b1)
		chk_rd(ADDR_FLAGS, 8'h40);
		core.rxOverflow <= 1'b0;
		core.rxCount <= 8'h00;
		core.rxFilteredCount <= 8'h00;
		pulse(4);
		tick(3);
		`CHK(rxBufferThresholdFlag, 1'b0)
		core.ffState <= 6'h2a;
		core.calActive <= 1'b1;
		core.synthLock <= 1'b1;
		core.ffTxState <= 1'b1;
		chk_rd(ADDR_STATE, 8'h6a);
		chk_rd(ADDR_FLAGS, 8'h06);
		core.calActive <= 1'b0;
		core.ffTxState <= 1'b0;
		core.ffRxState <= 1'b1;
		chk_rd(ADDR_STATE, 8'h2a);
		pulse(7);
		chk_rd(ADDR_STATE, 8'h2a);
		for (int i = 0; i < 4; i++) begin
			pulse(i);
			chk_rd(ADDR_FLAGS, i[0] ? 8'h05 : 8'h25);
		end
		chk_wr(ADDR_CLR_THR, 8'hf8, 8'hf8);
		core.clrHyst <= 3'h2;
		for (int i = 0; i < 11; i++) begin
			set_cca(ccaTab[i]);
			`CHK(channelClear, ccaTab[i][8])
		end
		set_cca(12'hdec);
		pulse(5);
		set_cca(12'hcf8);
		chk_rd(ADDR_FLAGS, 8'h0d);
		pulse(6);
		set_cca(12'hdec);
		chk_rd(ADDR_FLAGS, 8'h15);
		core.ackRequested <= 1'b1;
		chk_wr(ADDR_TIMING, 8'h01, 8'h01);
		frame_end();
		`CHK(ackAt >= ACK_CYC + 1 && ackAt <= ACK_CYC + 3, 1'b1)
		`CHK(holdCnt >= HOLD_CYC - 1 && holdCnt <= HOLD_CYC + 1, 1'b1)
		chk_wr(ADDR_TIMING, 8'h02, 8'h02);
		frame_end();
		`CHK(ackAt >= 32 && ackAt <= 34, 1'b1)
		`CHK(holdCnt, 0)
		report_and_stop();
	end
endmodule : radio_status_fifo_cca_regs_bench
